// *** rtl/dgv_defs.vh ***
// constants for the deserializer gpio / idle symbol / identification register slice
// assumes a 20 MHz register clock and an smbus host that is no faster than 100 kHz
//
// Operation
// - pin input register bits 2:0 return sampled levels of pins 2:0, read-only.
// - written pin output bits drive the matching pin output buffer when used as output.
// - pin output register bits 2:0 read/write, bits 7:3 reserved.
// - idle symbol replaces the parallel stream whenever no valid receive data arrives.
// - idle symbol defaults to K28.5, low byte resets 83, high bits reset 2.
// - identification register returns 2-bit read-only variant value in bits 1:0, bits 7:6 reserved.
// - identification bit 5 reads loop-through enable state, following its pin after reset.
// - pin input bits are meaningful only for inputs with enabled input buffers.
`ifndef DGV_DEFS_VH
`define DGV_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define DGV_OFS_PIN_INPUT 8'h05
`define DGV_OFS_PIN_OUTPUT 8'h06
`define DGV_OFS_IDLE_LOW 8'h0D
`define DGV_OFS_IDLE_HIGH 8'h0E
`define DGV_OFS_PART_ID 8'h1D

// ****************************************
// field positions
// ****************************************
`define DGV_PIN_MSB 2
`define DGV_IDLE_HIGH_MSB 1
`define DGV_ID_LOOP_BIT 5
`define DGV_ID_MODE_MSB 4
`define DGV_ID_MODE_LSB 3
`define DGV_ID_VAR_MSB 1

// ****************************************
// reset values
// ****************************************
`define DGV_RST_PIN_OUTPUT 3'h0
`define DGV_RST_IDLE_LOW 8'h83
`define DGV_RST_IDLE_HIGH 2'h2

// ****************************************
// smbus timing and framing
// ****************************************
`define DGV_BITS_PER_BYTE 4'h8
`define DGV_DEV_ADDR 7'h2D

`endif

// *** rtl/dgv_sync2.v ***
// two-stage synchroniser for levels arriving from outside the register clock domain
// assumes the caller holds reset low until the clock runs
`timescale 1ns/1ps

module dgv_sync2 #(
	parameter W = 1
) (
	// clock, enable, reset
	input wire clk,
	input wire ce,
	input wire rst_n,
	// levels
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);

	reg [W-1:0] meta_q;

	// first stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else if (ce) begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // dgv_sync2

// *** rtl/dgv_regs.v ***
// smbus register slice: gpio in/out, idle symbol insertion, identification register
// assumes scl and sda come from pins; mode, buffer enable and receive data are on clk
`timescale 1ns/1ps
`include "dgv_defs.vh"

module dgv_regs #(
	parameter [6:0] DEV_ADDR = `DGV_DEV_ADDR,
	// arbitrary part-type value
	parameter [1:0] VARIANT = 2'h0,
	parameter NPIN = 3
) (
	// clock, enable, reset
	input wire clk,
	input wire ce,
	input wire rstn,
	// smbus pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// general purpose pins
	input wire [NPIN-1:0] gp_pin_in,
	input wire [NPIN-1:0] gp_in_buf_en,
	output reg [NPIN-1:0] gp_pin_out,
	// loop-through pin and device mode
	input wire loopthru_en_pin,
	input wire [1:0] mode_state,
	// parallel receive stream
	input wire [9:0] rx_word,
	input wire rx_valid,
	output reg [9:0] out_word,
	output reg out_is_idle
);

	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	reg rst_meta_q;
	reg rst_n_q;
	wire [NPIN+2:0] pins_s;
	wire scl_s;
	wire sda_s;
	wire loop_s;
	wire [NPIN-1:0] gp_s;

	// asserted at once, released after two edges
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	dgv_sync2 #(.W(NPIN + 3)) u_sync (
		.clk(clk),
		.ce(ce),
		.rst_n(rst_n_q),
		.async_in({~scl_in, ~sda_in, loopthru_en_pin, gp_pin_in}), // inverted: cleared stages read as idle bus
		.sync_out(pins_s)
	);

	assign scl_s = ~pins_s[NPIN+2];
	assign sda_s = ~pins_s[NPIN+1];
	assign loop_s = pins_s[NPIN];
	assign gp_s = pins_s[NPIN-1:0];

	// ****************************************
	// bus condition detection
	// ****************************************
	reg scl_p_q;
	reg sda_p_q;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;

	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce) begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// ****************************************
	// registers and read multiplexer
	// ****************************************
	reg [NPIN-1:0] pin_output_data_q;
	reg [7:0] idle_symbol_low_q;
	reg [1:0] idle_symbol_high_q;
	reg [7:0] ptr_q;
	reg [7:0] rd_data;
	wire [9:0] idle_word;

	assign idle_word = {idle_symbol_high_q, idle_symbol_low_q};

	// unlisted offsets and reserved bits read as zero
	always @* begin
		rd_data = 8'h00;
		case (ptr_q)
			`DGV_OFS_PIN_INPUT: begin
				// only inputs with live buffers show a level
				rd_data[NPIN-1:0] = gp_s & gp_in_buf_en;
			end
			`DGV_OFS_PIN_OUTPUT: begin
				rd_data[NPIN-1:0] = pin_output_data_q;
			end
			`DGV_OFS_IDLE_LOW: begin
				rd_data = idle_symbol_low_q;
			end
			`DGV_OFS_IDLE_HIGH: begin
				rd_data[`DGV_IDLE_HIGH_MSB:0] = idle_symbol_high_q;
			end
			`DGV_OFS_PART_ID: begin
				rd_data[`DGV_ID_LOOP_BIT] = loop_s;
				rd_data[`DGV_ID_MODE_MSB:`DGV_ID_MODE_LSB] = mode_state;
				rd_data[`DGV_ID_VAR_MSB:0] = VARIANT;
			end
			default: begin
				rd_data = 8'h00;
			end
		endcase
	end

	// ****************************************
	// smbus slave state machine
	// ****************************************
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_A_ACK = 3'h2;
	localparam [2:0] ST_CMD = 3'h3;
	localparam [2:0] ST_C_ACK = 3'h4;
	localparam [2:0] ST_WDATA = 3'h5;
	localparam [2:0] ST_W_ACK = 3'h6;
	localparam [2:0] ST_RDATA = 3'h7;

	reg [2:0] state_q;
	reg [3:0] cnt_q;
	reg [7:0] shift_q;
	reg [7:0] tx_q;
	reg rw_q;
	reg r_ack_q;
	reg nack_q;
	wire byte_done;
	wire wr_en;

	assign byte_done = (cnt_q == `DGV_BITS_PER_BYTE);
	assign wr_en = (state_q == ST_WDATA) & scl_fall & byte_done;

	// writes land on the falling edge after the eighth data bit, as the ack is driven; pointer auto-increments
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			rw_q <= 1'b0;
			r_ack_q <= 1'b0;
			nack_q <= 1'b0;
			ptr_q <= 8'h00;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else if (ce) begin
			if (bus_start) begin
				state_q <= ST_ADDR;
				cnt_q <= 4'h0;
				sda_oe <= 1'b0;
				r_ack_q <= 1'b0;
			end else if (bus_stop) begin
				state_q <= ST_IDLE;
				sda_oe <= 1'b0;
				r_ack_q <= 1'b0;
			end else if (scl_rise) begin
				if (state_q == ST_RDATA && r_ack_q) begin
					nack_q <= sda_s;
				end else if (!byte_done) begin
					shift_q <= {shift_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'h1;
				end
			end else if (scl_fall) begin
				case (state_q)
					ST_ADDR: begin
						if (byte_done && shift_q[7:1] == DEV_ADDR) begin
							rw_q <= shift_q[0];
							sda_oe <= 1'b1;
							state_q <= ST_A_ACK;
						end else if (byte_done) begin
							state_q <= ST_IDLE;
						end
					end
					ST_A_ACK: begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							// first data bit goes out on this falling edge
							tx_q <= {rd_data[6:0], 1'b0};
							sda_oe <= ~rd_data[7];
							state_q <= ST_RDATA;
						end else begin
							sda_oe <= 1'b0;
							state_q <= ST_CMD;
						end
					end
					ST_CMD: begin
						if (byte_done) begin
							ptr_q <= shift_q;
							sda_oe <= 1'b1;
							state_q <= ST_C_ACK;
						end
					end
					ST_C_ACK, ST_W_ACK: begin
						sda_oe <= 1'b0;
						cnt_q <= 4'h0;
						state_q <= ST_WDATA;
					end
					ST_WDATA: begin
						if (byte_done) begin
							ptr_q <= ptr_q + 8'h01;
							sda_oe <= 1'b1;
							state_q <= ST_W_ACK;
						end
					end
					ST_RDATA: begin
						if (r_ack_q) begin
							r_ack_q <= 1'b0;
							cnt_q <= 4'h0;
							if (nack_q) begin
								state_q <= ST_IDLE;
							end else begin
								tx_q <= {rd_data[6:0], 1'b0};
								sda_oe <= ~rd_data[7];
							end
						end else if (byte_done) begin
							// release for the host's ack bit
							sda_oe <= 1'b0;
							r_ack_q <= 1'b1;
							ptr_q <= ptr_q + 8'h01;
						end else begin
							sda_oe <= ~tx_q[7];
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************
	// writable registers
	// ****************************************
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_output_data_q <= `DGV_RST_PIN_OUTPUT;
			idle_symbol_low_q <= `DGV_RST_IDLE_LOW;
			idle_symbol_high_q <= `DGV_RST_IDLE_HIGH;
		end else if (ce && wr_en) begin
			// reserved bits and offsets are simply not stored
			case (ptr_q)
				`DGV_OFS_PIN_OUTPUT: begin
					pin_output_data_q <= shift_q[NPIN-1:0];
				end
				`DGV_OFS_IDLE_LOW: begin
					idle_symbol_low_q <= shift_q;
				end
				`DGV_OFS_IDLE_HIGH: begin
					idle_symbol_high_q <= shift_q[`DGV_IDLE_HIGH_MSB:0];
				end
				default: begin
					idle_symbol_low_q <= idle_symbol_low_q;
				end
			endcase
		end
	end

	// ****************************************
	// pin drive and idle symbol insertion
	// ****************************************
	// pin direction lives in the neighbouring config block; this only supplies the level
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			gp_pin_out <= {NPIN{1'b0}};
			out_word <= 10'h000;
			out_is_idle <= 1'b1;
		end else if (ce) begin
			gp_pin_out <= pin_output_data_q;
			if (rx_valid) begin
				out_word <= rx_word;
				out_is_idle <= 1'b0;
			end else begin
				out_word <= idle_word;
				out_is_idle <= 1'b1;
			end
		end
	end

endmodule // dgv_regs

// *** tb/dgv_regs_chk.sv ***
// checker for the register slice, bound to its top module
// assumes ce high for a few cycles after reset release
`timescale 1ns/1ps
module dgv_regs_chk #(
	parameter NPIN = 3
) (
	// clock, enable, reset
	input wire clk,
	input wire ce,
	input wire rstn,
	// smbus pins
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	// general purpose pins
	input wire [NPIN-1:0] gp_pin_in,
	input wire [NPIN-1:0] gp_in_buf_en,
	input wire [NPIN-1:0] gp_pin_out,
	// loop pin and mode
	input wire loopthru_en_pin,
	input wire [1:0] mode_state,
	// stream
	input wire [9:0] rx_word,
	input wire rx_valid,
	input wire [9:0] out_word,
	input wire out_is_idle
);
	// internal reset trails rstn by two edges
	reg [2:0] rel_q;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rel_q <= 3'h0;
		end else if (rel_q != 3'h4) begin
			rel_q <= rel_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_idle_flag: assert property (rel_q == 3'h4 && ce && !rx_valid |=> out_is_idle)
		else $error("idle flag");
	chk_data_pass: assert property (rel_q == 3'h4 && ce && rx_valid |=> !out_is_idle && out_word == $past(rx_word))
		else $error("data pass");
	chk_idle_steady: assert property (rel_q == 3'h4 && out_is_idle && $past(out_is_idle) && !sda_oe |-> $stable(out_word))
		else $error("idle steady");
	chk_ce_freeze: assert property (!ce |=> $stable(out_word) && $stable(gp_pin_out))
		else $error("ce freeze");
	chk_gp_cause: assert property (!$stable(gp_pin_out) |-> sda_oe || $past(sda_oe))
		else $error("gp cause");
	chk_sda_low: assert property (!sda_out)
		else $error("sda level");
	chk_ack_after: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
		else $error("ack timing");
	chk_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("sda hold");
endmodule // dgv_regs_chk

bind dgv_regs dgv_regs_chk #(.NPIN(NPIN)) chk_u (.clk(clk), .ce(ce), .rstn(rstn), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .gp_pin_in(gp_pin_in), .gp_in_buf_en(gp_in_buf_en),
	.gp_pin_out(gp_pin_out), .loopthru_en_pin(loopthru_en_pin), .mode_state(mode_state), .rx_word(rx_word),
	.rx_valid(rx_valid), .out_word(out_word), .out_is_idle(out_is_idle));

// *** tb/dgv_smbus_host.sv ***
// smbus host model: bit-banged master, write and three-byte read
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ps
`include "dgv_defs.vh"
module dgv_smbus_host (
	// clock and bus
	input wire clk,
	input wire sda,
	output logic scl,
	output logic sda_oe
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	// 210 clocks a bit keeps the bus under 100 kHz
	task automatic step(input logic s, input logic d);
		repeat (60) @(posedge clk);
		scl <= s;
		sda_oe <= !d;
	endtask
	task automatic bitx(input logic d, output logic r);
		step(1'b0, d);
		step(1'b1, d);
		repeat (30) @(posedge clk);
		r = sda;
		step(1'b0, d);
	endtask
	task automatic byte_x(input logic [7:0] b, input logic last, output logic [7:0] r, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], r[i]);
		end
		bitx(last, nak);
	endtask
	task automatic start;
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop;
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic wr(input logic [7:0] off, input logic [15:0] d, output logic nak);
		logic [7:0] r;
		logic [3:0] n;
		start;
		byte_x({`DGV_DEV_ADDR, 1'b0}, 1'b1, r, n[0]);
		byte_x(off, 1'b1, r, n[1]);
		byte_x(d[15:8], 1'b1, r, n[2]);
		byte_x(d[7:0], 1'b1, r, n[3]);
		stop;
		nak = |n;
	endtask
	task automatic rd(input logic [7:0] off, output logic [23:0] v, output logic nak);
		logic [7:0] r;
		logic [5:0] n;
		start;
		byte_x({`DGV_DEV_ADDR, 1'b0}, 1'b1, r, n[0]);
		byte_x(off, 1'b1, r, n[1]);
		start;
		byte_x({`DGV_DEV_ADDR, 1'b1}, 1'b1, r, n[2]);
		byte_x(8'hFF, 1'b0, v[23:16], n[3]);
		byte_x(8'hFF, 1'b0, v[15:8], n[4]);
		byte_x(8'hFF, 1'b1, v[7:0], n[5]);
		stop;
		nak = |n[2:0];
	endtask
endmodule // dgv_smbus_host

// *** tb/dgv_regs_test.sv ***
// bench for the register slice: smbus accesses with expected values
// assumes the host model and the bound checker
`timescale 1ns/1ps
module dgv_regs_test;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic rstn = 1'b0;
	logic [2:0] gp_in = 3'h5;
	logic [2:0] buf_en = 3'h7;
	logic [9:0] rx_word = 10'h2AA;
	logic rx_valid = 1'b0;
	logic loop_pin = 1'b1;
	logic [1:0] mode = 2'h3;
	wire scl, host_oe, sda_oe, out_is_idle;
	wire [9:0] out_word;
	wire [2:0] gp_out;
	wire sda = !(sda_oe || host_oe);
	int err_total = 0;
	int cmp_count = 0;
	dgv_regs #(.VARIANT(2'h1)) dut_u (.clk(clk), .ce(ce), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe(sda_oe), .gp_pin_in(gp_in), .gp_in_buf_en(buf_en), .gp_pin_out(gp_out), .loopthru_en_pin(loop_pin),
		.mode_state(mode), .rx_word(rx_word), .rx_valid(rx_valid), .out_word(out_word), .out_is_idle(out_is_idle));
	dgv_smbus_host host_u (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
	task automatic chk(input string name, input logic [24:0] exp, input logic [24:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask
	task automatic rd(input logic [7:0] off, input logic [23:0] exp);
		logic [23:0] v;
		logic nak;
		host_u.rd(off, v, nak);
		chk("read", {1'b0, exp}, {nak, v});
	endtask
	task automatic wr(input logic [7:0] off, input logic [15:0] d);
		logic nak;
		host_u.wr(off, d, nak);
		chk("write ack", 25'h0, {24'h0, nak});
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		forever #25 clk = !clk;
	end
	// a full run takes about 88000 cycles
	initial begin
		repeat (98000) @(posedge clk);
		err_total++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (10) @(posedge clk);
		rd(8'h0D, 24'h830200);
		rd(8'h05, 24'h050000);
		wr(8'h06, 16'hFFAA);
		chk("pin out", 25'h7, {22'h0, gp_out});
		gp_in <= 3'h6;
		buf_en <= 3'h3;
		rd(8'h05, 24'h020700);
		rd(8'h1D, 24'h390000);
		loop_pin <= 1'b0;
		mode <= 2'h0;
		rd(8'h1D, 24'h010000);
		wr(8'h0D, 16'h7CFD);
		rd(8'h0D, 24'h7C0100);
		chk("idle word", 25'h17C, {15'h0, out_word});
		chk("idle flag", 25'h1, {24'h0, out_is_idle});
		rx_valid <= 1'b1;
		repeat (2) @(posedge clk);
		chk("data word", 25'h2AA, {15'h0, out_word});
		ce <= 1'b0;
		rx_word <= 10'h155;
		repeat (3) @(posedge clk);
		chk("held word", 25'h2AA, {15'h0, out_word});
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk("next word", 25'h155, {15'h0, out_word});
		// mid-run reset: written registers fall back to their defaults
		rx_valid <= 1'b0;
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		chk("reset idle word", 25'h283, {15'h0, out_word});
		chk("reset idle flag", 25'h1, {24'h0, out_is_idle});
		chk("reset pin out", 25'h0, {22'h0, gp_out});
		complete_run;
	end
endmodule // dgv_regs_test
